// file: src/ccs_bus_if.sv
`timescale 1ns/1ns
// Purpose: multiplexed system bus between sequencer and memory side
// Assumes: testbench resolves data bus from the two enables
// Notes:   interrupt request low when any open-drain drive is on
interface ccs_bus_if;
    // timing and command
    logic       cycle_strobe;
    logic [4:0] cycle_command_lines;
    // data bus
    logic [7:0] cpu_db_o;
    logic       cpu_db_oe;
    logic [7:0] mem_db_o;
    logic       mem_db_oe;
    logic [7:0] db_i;
    // interrupt
    logic       int_req_oe;
    logic       int_req_n_i;
    modport cpu (output cycle_strobe, output cycle_command_lines, output cpu_db_o,
                 output cpu_db_oe, input db_i, input int_req_n_i);
    modport mem (input cycle_strobe, input cycle_command_lines, output mem_db_o,
                 output mem_db_oe, input db_i, output int_req_oe);
endinterface : ccs_bus_if

// file: src/ccs_cpu.sv
`timescale 1ns/1ns
// Purpose: CPU end; issues one command per cycle, runs port bits and mask
// Assumes: memory end keeps its own rules; pins arrive asynchronous
// Notes:   tiny opcode subset exercises every cycle kind except 0E and 11
module ccs_cpu (
    // clock and reset
    input  wire logic SYS_CLK,
    input  wire logic RST_N,
    // bus
    ccs_bus_if.cpu    BUS,
    // port pins, open drain
    input  wire logic [7:0] PORT_PIN_I,
    output logic      [7:0] PORT_PIN_O,
    output logic      [7:0] PORT_PIN_OE,
    // interrupt mask
    output logic            INTERRUPT_MASK_OUT,
    // observation
    output logic      [7:0] ACC_OUT
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_FETCH = 3'b000,
        ST_EXEC1 = 3'b001,
        ST_EXEC2 = 3'b010,
        ST_ACK1  = 3'b011,
        ST_ACK2  = 3'b100,
        ST_ACK3  = 3'b101
    } ccs_state_t;
    ccs_state_t  state_r, state_nxt;
    logic [2:0]  clk_cnt_r;
    logic        long_r;
    logic [4:0]  cmd_r;
    logic [7:0]  ir_r, acc_r, scr_r, latch_r;
    logic        mask_r, strobe_r;
    logic [7:0]  db_out_r;
    logic [7:0]  pin_s1_r, pin_s2_r;
    logic        irq_s1_r, irq_s2_r;
    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic logic is_port(input logic [7:0] op, input logic [7:0] kind);
        return (op & ccs_pkg::OP_PORT_MASK) == kind;
    endfunction : is_port
    function automatic logic is_store(input logic [7:0] op);
        return op == ccs_pkg::OP_STORE_MEM || op == ccs_pkg::OP_STORE_SCR;
    endfunction : is_store
    function automatic logic is_multi(input logic [7:0] op);
        return op == ccs_pkg::OP_LOAD_MEM || op == ccs_pkg::OP_ADD_MEM || is_store(op)
            || op == ccs_pkg::OP_LOAD_K || op == ccs_pkg::OP_M2M;
    endfunction : is_multi
    // ----------------------------------------------------------------
    // decode of current and newly fetched opcode
    // ----------------------------------------------------------------
    wire logic [2:0] last_cnt = long_r ? 3'(ccs_pkg::LONG_CLKS - 1)
                                       : 3'(ccs_pkg::SHORT_CLKS - 1);
    wire logic       end_cyc  = clk_cnt_r == last_cnt;
    wire logic [2:0] cnt_inc  = clk_cnt_r + 3'h1;
    wire logic       is_out   = is_port(ir_r, ccs_pkg::OP_OUT_PORT);
    wire logic       is_in    = is_port(ir_r, ccs_pkg::OP_IN_PORT);
    wire logic [7:0] op_new   = BUS.db_i;
    wire logic       take_irq = !mask_r && !irq_s2_r;
    wire logic       cpu_tx   = state_r == ST_EXEC1 && is_store(ir_r);
    ccs_pkg::ccs_dest_t dest;
    logic [4:0]      cmd_nxt;
    logic            long_nxt;
    always_comb begin
        state_nxt = state_r;
        cmd_nxt   = ccs_pkg::CMD_FETCH;
        long_nxt  = 1'b0;
        dest      = ccs_pkg::DST_NONE;
        case (state_r)
            ST_FETCH: begin
                dest = ccs_pkg::DST_IR;
                if (take_irq) begin
                    state_nxt = ST_ACK1;
                    cmd_nxt   = ccs_pkg::CMD_ACK;
                end else if (is_multi(op_new)) begin
                    state_nxt = ST_EXEC1;
                    if (is_store(op_new)) begin
                        cmd_nxt  = ccs_pkg::CMD_WR_DC;
                        long_nxt = 1'b1;
                    end else if (op_new == ccs_pkg::OP_LOAD_K) begin
                        cmd_nxt  = ccs_pkg::CMD_PC1_K;
                        long_nxt = 1'b1;
                    end else if (op_new == ccs_pkg::OP_M2M) begin
                        cmd_nxt = ccs_pkg::CMD_M2M_C;
                    end else begin
                        cmd_nxt = ccs_pkg::CMD_RD_DC;
                    end
                end else begin
                    cmd_nxt = ccs_pkg::CMD_FETCH;
                end
            end
            ST_EXEC1: begin
                if (ir_r == ccs_pkg::OP_LOAD_MEM)
                    dest = ccs_pkg::DST_ACC;
                else if (ir_r == ccs_pkg::OP_ADD_MEM)
                    dest = ccs_pkg::DST_ACC_A;
                else if (ir_r == ccs_pkg::OP_LOAD_K)
                    dest = ccs_pkg::DST_SCR;
                state_nxt = ST_FETCH;
                cmd_nxt   = ccs_pkg::CMD_FETCH;
            end
            ST_ACK1: begin
                state_nxt = ST_ACK2;
                cmd_nxt   = ccs_pkg::CMD_VEC_LO;
            end
            ST_ACK2: begin
                state_nxt = ST_ACK3;
                cmd_nxt   = ccs_pkg::CMD_VEC_HI;
            end
            ST_ACK3: begin
                state_nxt = ST_FETCH;
                cmd_nxt   = ccs_pkg::CMD_FETCH;
            end
            default: state_nxt = ST_FETCH;
        endcase
    end
    // ----------------------------------------------------------------
    // cycle timing and command
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            clk_cnt_r <= 3'h0;
            strobe_r  <= 1'b0;
            state_r   <= ST_FETCH;
            cmd_r     <= ccs_pkg::CMD_FETCH;
            long_r    <= 1'b0;
        end else begin
            clk_cnt_r <= end_cyc ? 3'h0 : cnt_inc;
            strobe_r  <= !end_cyc && cnt_inc == last_cnt;
            if (end_cyc) begin
                state_r <= state_nxt;
                cmd_r   <= cmd_nxt;
                long_r  <= long_nxt;
            end
        end
    end
    // ----------------------------------------------------------------
    // data path: capture at cycle end
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ir_r    <= ccs_pkg::RESET_OPCODE;
            acc_r   <= 8'h00;
            scr_r   <= 8'h00;
            latch_r <= 8'h00;
            mask_r  <= 1'b1;
        end else if (end_cyc) begin
            case (dest)
                ccs_pkg::DST_IR:    ir_r  <= BUS.db_i;
                ccs_pkg::DST_ACC:   acc_r <= BUS.db_i;
                ccs_pkg::DST_ACC_A: acc_r <= acc_r + BUS.db_i;
                ccs_pkg::DST_SCR:   scr_r <= BUS.db_i;
                default:            acc_r <= acc_r;
            endcase
            if (state_r == ST_FETCH) begin
                if (is_out)
                    latch_r <= acc_r;
                if (is_in)
                    acc_r <= pin_s2_r;
                if (ir_r == ccs_pkg::OP_ENABLE_INT)
                    mask_r <= 1'b0;
                if (ir_r == ccs_pkg::OP_DISABLE_INT)
                    mask_r <= 1'b1;
            end
            if (state_r == ST_FETCH && take_irq) begin
                mask_r <= 1'b1;
                ir_r   <= ccs_pkg::RESET_OPCODE;
            end
        end
    end
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pin_s1_r <= 8'hFF;
            pin_s2_r <= 8'hFF;
            irq_s1_r <= 1'b1;
            irq_s2_r <= 1'b1;
        end else begin
            pin_s1_r <= PORT_PIN_I;
            pin_s2_r <= pin_s1_r;
            irq_s1_r <= BUS.int_req_n_i;
            irq_s2_r <= irq_s1_r;
        end
    end
    // ----------------------------------------------------------------
    // bus data: accumulator or scratchpad, registered
    // ----------------------------------------------------------------
    wire logic [7:0] db_out_nxt = ir_r == ccs_pkg::OP_STORE_SCR ? scr_r : acc_r;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N)
            db_out_r <= 8'h00;
        else
            db_out_r <= db_out_nxt;
    end
    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign BUS.cycle_strobe        = strobe_r;
    assign BUS.cycle_command_lines = cmd_r;
    assign BUS.cpu_db_o            = db_out_r;
    assign BUS.cpu_db_oe           = cpu_tx;
    assign PORT_PIN_O              = 8'h00;
    assign PORT_PIN_OE             = latch_r;
    assign INTERRUPT_MASK_OUT      = mask_r;
    assign ACC_OUT                 = acc_r;
endmodule : ccs_cpu

// file: src/ccs_mem.sv
`timescale 1ns/1ns
// Purpose: memory end; decodes commands, holds address counters and array
// Assumes: one command per cycle, cycle ends at strobe
// Notes:   drives data bus only when it is the source
module ccs_mem #(
    parameter int DEPTH = 256
) (
    // clock and reset
    input  wire logic SYS_CLK,
    input  wire logic RST_N,
    // bus
    ccs_bus_if.mem    BUS,
    // interrupt source
    input  wire logic IRQ_REQ,
    // program load
    input  wire logic       LOAD_WE,
    input  wire logic [7:0] LOAD_ADDR,
    input  wire logic [7:0] LOAD_DATA
);
    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [7:0] mem_r [DEPTH];
    logic [7:0] program_counter_r, data_counter_r;
    wire logic [4:0] cmd = BUS.cycle_command_lines;
    wire logic src_pc  = cmd == ccs_pkg::CMD_FETCH || cmd == ccs_pkg::CMD_VEC_LO
                      || cmd == ccs_pkg::CMD_VEC_HI;
    wire logic src_dc  = cmd == ccs_pkg::CMD_RD_DC || cmd == ccs_pkg::CMD_PC1_K;
    wire logic is_m2m  = cmd == ccs_pkg::CMD_M2M_C || cmd == ccs_pkg::CMD_M2M_E
                      || cmd == ccs_pkg::CMD_M2M_11;
    wire logic [7:0] rd_addr = src_pc ? program_counter_r : data_counter_r;
    // ----------------------------------------------------------------
    // command execution at cycle end
    // ----------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            program_counter_r <= 8'h00;
            data_counter_r    <= 8'h00;
        end else if (BUS.cycle_strobe) begin
            if (src_pc)
                program_counter_r <= program_counter_r + 8'h01;
            if (src_dc || cmd == ccs_pkg::CMD_WR_DC || is_m2m)
                data_counter_r <= data_counter_r + 8'h01;
            if (is_m2m)
                data_counter_r <= BUS.db_i;
        end
    end
    always_ff @(posedge SYS_CLK) begin
        if (LOAD_WE)
            mem_r[LOAD_ADDR] <= LOAD_DATA;
        else if (BUS.cycle_strobe && cmd == ccs_pkg::CMD_WR_DC)
            mem_r[data_counter_r] <= BUS.db_i;
    end
    assign BUS.mem_db_o   = mem_r[rd_addr];
    assign BUS.mem_db_oe  = src_pc || src_dc || is_m2m;
    assign BUS.int_req_oe = IRQ_REQ;
endmodule : ccs_mem

// file: src/ccs_pkg.sv
// Purpose: shared constants for the cycle command sequencer and its memory end
// Assumes: one 100 MHz clock, one cycle command issued per instruction cycle
// Notes:   command codes are the five-line levels, high as 1
//
// Overview of operation
// - command lines set early, held whole cycle
// - exactly one command per instruction cycle
// - command code is five line levels, hex
// - last cycle fetches next opcode into register
// - internal instruction: single cycle issuing code 0
// - multi-cycle instruction ends with code 0 cycle
// - following cycles are one of five kinds
// - accumulator write to memory uses long cycle
// - scratchpad output uses long cycle
// - reads go to four destinations
// - devices classify transfer from command code only
// - codes C, E, 11: memory to memory
// - port latch written only from accumulator
// - latched 1 pulls pin low
// - pin is wired-AND; read returns pin
// - software clears latch before reading port; the test program's first A0 read runs with the latch at 1B
// - mask clears on enable, sets on disable/ack
// - interrupt request is wired-AND, pulled up
// - short cycle four clocks, long six
// - cycle ends at trailing strobe edge
// - acknowledge issues 1C, 0F, 13, 00
package ccs_pkg;
    localparam int CMD_W        = 5;
    localparam int DATA_W       = 8;
    localparam int SHORT_CLKS   = 4;
    localparam int LONG_CLKS    = 6;
    localparam logic [4:0] CMD_FETCH   = 5'h00;
    localparam logic [4:0] CMD_RD_DC   = 5'h02;
    localparam logic [4:0] CMD_WR_DC   = 5'h05;
    localparam logic [4:0] CMD_PC1_K   = 5'h07;
    localparam logic [4:0] CMD_VEC_LO  = 5'h0F;
    localparam logic [4:0] CMD_M2M_C   = 5'h0C;
    localparam logic [4:0] CMD_M2M_E   = 5'h0E;
    localparam logic [4:0] CMD_M2M_11  = 5'h11;
    localparam logic [4:0] CMD_VEC_HI  = 5'h13;
    localparam logic [4:0] CMD_ACK     = 5'h1C;
    localparam logic [7:0] OP_ENABLE_INT  = 8'h1B;
    localparam logic [7:0] OP_DISABLE_INT = 8'h1A;
    localparam logic [7:0] OP_LOAD_MEM    = 8'h16;
    localparam logic [7:0] OP_ADD_MEM     = 8'h88;
    localparam logic [7:0] OP_STORE_MEM   = 8'h17;
    localparam logic [7:0] OP_STORE_SCR   = 8'h18;
    localparam logic [7:0] OP_LOAD_K      = 8'h08;
    localparam logic [7:0] OP_M2M         = 8'h2A;
    localparam logic [7:0] OP_OUT_PORT    = 8'hB0;
    localparam logic [7:0] OP_IN_PORT     = 8'hA0;
    localparam logic [7:0] OP_PORT_MASK   = 8'hF0;
    localparam logic [7:0] RESET_OPCODE   = 8'h2B;
    typedef enum logic [2:0] {
        DST_NONE  = 3'b000,
        DST_IR    = 3'b001,
        DST_ACC_A = 3'b010,
        DST_SCR   = 3'b011,
        DST_ACC   = 3'b100
    } ccs_dest_t;
endpackage : ccs_pkg

// file: verification/ccs_assertions.sv
// Purpose: bus rule checker beside the interface
// Assumes: one clock, async low reset
// Notes:   long cycles are commands 05 and 07
`timescale 1ns/1ns
module ccs_assertions (
    // clock and reset
    input wire logic       SYS_CLK,
    input wire logic       RST_N,
    // bus
    input wire logic       cycle_strobe,
    input wire logic [4:0] cycle_command_lines,
    input wire logic       cpu_db_oe,
    input wire logic       mem_db_oe,
    // interrupt
    input wire logic       INTERRUPT_MASK_OUT
);
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    wire        long_w;
    wire [4:0]  c;
    assign c = cycle_command_lines;
    assign long_w = (c == 5'h05) || (c == 5'h07);
    assign cnt_nxt = cycle_strobe ? 3'h0 : cnt_r + 3'h1;
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) cnt_r <= 3'h0;
        else cnt_r <= cnt_nxt;
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    property p_hold; $changed(c) |-> $past(cycle_strobe); endproperty
    property p_len; cycle_strobe |-> cnt_r == (long_w ? 3'h5 : 3'h3); endproperty
    property p_gap; cycle_strobe |=> !cycle_strobe [*3]; endproperty
    property p_quiet; cpu_db_oe |-> long_w; endproperty
    property p_store; cycle_strobe && c == 5'h05 |-> cpu_db_oe; endproperty
    property p_fight; cpu_db_oe |-> !mem_db_oe; endproperty
    property p_m2m;
        cycle_strobe && (c == 5'h0C || c == 5'h0E || c == 5'h11) |-> mem_db_oe && !cpu_db_oe;
    endproperty
    property p_fetch; cycle_strobe && c == 5'h00 |-> mem_db_oe && !cpu_db_oe; endproperty
    property p_ack;
        cycle_strobe && (c == 5'h1C || c == 5'h0F || c == 5'h13) |=>
            c == ($past(c) == 5'h1C ? 5'h0F : $past(c) == 5'h0F ? 5'h13 : 5'h00);
    endproperty
    property p_mask; cycle_strobe && c == 5'h1C |-> INTERRUPT_MASK_OUT; endproperty
    a_hold: assert property (p_hold) else $error("command moved mid cycle");
    a_len: assert property (p_len) else $error("bad cycle length");
    a_gap: assert property (p_gap) else $error("strobe too close");
    a_quiet: assert property (p_quiet) else $error("cpu drives bus");
    a_store: assert property (p_store) else $error("store not driven");
    a_fight: assert property (p_fight) else $error("bus contention");
    a_m2m: assert property (p_m2m) else $error("m2m source wrong");
    a_fetch: assert property (p_fetch) else $error("fetch source wrong");
    a_ack: assert property (p_ack) else $error("ack order wrong");
    a_mask: assert property (p_mask) else $error("mask low on ack");
    c_store: cover property (cycle_strobe && c == 5'h05);
    c_m2m: cover property (cycle_strobe && c == 5'h0C);
    c_ack: cover property (cycle_strobe && c == 5'h1C);
endmodule : ccs_assertions

// file: verification/cpu_cycle_command_sequencer_test.sv
// Purpose: both ends joined, program run and checked
// Assumes: counters start at 0, unused memory holds no-ops
// Notes:   pins are open drain, external side drives 7F
`timescale 1ns/1ns
module cpu_cycle_command_sequencer_test;
    logic       sys_clk;
    logic       rst_n;
    logic       irq_req;
    logic       load_we;
    logic [7:0] load_addr;
    logic [7:0] load_data;
    logic [7:0] pin_i;
    logic [7:0] pin_oe;
    logic [7:0] acc;
    logic       mask;
    logic [4:0] cq[$];
    logic [7:0] sq[$];
    int         errors;
    int         checked;
    ccs_bus_if bus ();
    assign bus.db_i = bus.cpu_db_oe ? bus.cpu_db_o : bus.mem_db_oe ? bus.mem_db_o : 8'hFF;
    assign bus.int_req_n_i = ~bus.int_req_oe;
    assign pin_i = ~pin_oe & 8'h7F;
    ccs_cpu i_ccs_cpu (.SYS_CLK(sys_clk), .RST_N(rst_n), .BUS(bus.cpu), .PORT_PIN_I(pin_i),
        .PORT_PIN_O(), .PORT_PIN_OE(pin_oe), .INTERRUPT_MASK_OUT(mask), .ACC_OUT(acc));
    ccs_mem i_ccs_mem (.SYS_CLK(sys_clk), .RST_N(rst_n), .BUS(bus.mem), .IRQ_REQ(irq_req),
        .LOAD_WE(load_we), .LOAD_ADDR(load_addr), .LOAD_DATA(load_data));
    ccs_assertions i_ccs_assertions (.SYS_CLK(sys_clk), .RST_N(rst_n),
        .cycle_strobe(bus.cycle_strobe), .cycle_command_lines(bus.cycle_command_lines),
        .cpu_db_oe(bus.cpu_db_oe), .mem_db_oe(bus.mem_db_oe), .INTERRUPT_MASK_OUT(mask));
    // ---------------------------------------------
    // shared tasks
    // ---------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_q(input int n);
        for (int k = 0; k < 3000 && cq.size() < n; k++) @(negedge sys_clk);
    endtask : wait_q
    task automatic summarize;
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    // commands recorded at each cycle end
    always @(negedge sys_clk) begin
        if (rst_n && bus.cycle_strobe === 1'b1) begin
            cq.push_back(bus.cycle_command_lines);
            if (bus.cycle_command_lines === 5'h05) sq.push_back(bus.cpu_db_o);
        end
    end
    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic test_reset;
        logic [7:0] prog [11];
        prog = '{8'h1B, 8'h16, 8'hB0, 8'hA0, 8'h17, 8'h08, 8'h2A,
                 8'h16, 8'hB0, 8'hA0, 8'h18};
        rst_n = 1'b0;
        for (int a = 0; a < 256; a++) begin
            @(negedge sys_clk);
            load_we = 1'b1;
            load_addr = a[7:0];
            load_data = (a < 11) ? prog[a] : (a[7:0] == 8'hA0) ? 8'h00 : 8'h2B;
        end
        @(negedge sys_clk);
        load_we = 1'b0;
        check({3'h0, bus.cycle_command_lines}, 8'h00);
        check({7'h0, mask}, 8'h01);
        check(pin_oe, 8'h00);
        cq.delete();
        rst_n = 1'b1;
        $display("test_reset done");
    endtask : test_reset
    task automatic test_program;
        logic [4:0] exp [17];
        exp = '{5'h00, 5'h00, 5'h02, 5'h00, 5'h00, 5'h00, 5'h05, 5'h00, 5'h07, 5'h00, 5'h0C,
                5'h00, 5'h02, 5'h00, 5'h00, 5'h00, 5'h05};
        wait_q(11);
        for (int i = 0; i < 11; i++) check({3'h0, cq[i]}, {3'h0, exp[i]});
        check(pin_oe, 8'h1B);
        check(acc, ~8'h1B & 8'h7F);
        check(sq.size() > 0 ? sq[0] : 8'hXX, ~8'h1B & 8'h7F);
        check({7'h0, mask}, 8'h00);
        wait_q(17);
        for (int i = 11; i < 17; i++) check({3'h0, cq[i]}, {3'h0, exp[i]});
        check(sq.size() > 1 ? sq[1] : 8'hXX, 8'hB0);
        check(acc, 8'h7F);
        check(pin_oe, 8'h00);
        $display("test_program done");
    endtask : test_program
    task automatic test_interrupt;
        int idx;
        idx = -1;
        irq_req = 1'b1;
        for (int k = 0; k < 3000 && idx < 0; k++) begin
            @(negedge sys_clk);
            foreach (cq[i]) if (idx < 0 && cq[i] === 5'h1C) idx = i;
        end
        irq_req = 1'b0;
        check(idx >= 0 ? 8'h01 : 8'h00, 8'h01);
        if (idx < 0) idx = 0;
        wait_q(idx + 4);
        check({3'h0, cq[idx + 1]}, 8'h0F);
        check({3'h0, cq[idx + 2]}, 8'h13);
        check({3'h0, cq[idx + 3]}, 8'h00);
        check({7'h0, mask}, 8'h01);
        $display("test_interrupt done");
    endtask : test_interrupt
    // ---------------------------------------------
    // clock, watchdog, main
    // ---------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #300000;
        errors++;
        summarize();
    end
    initial begin
        errors = 0;
        checked = 0;
        rst_n = 1'b0;
        irq_req = 1'b0;
        load_we = 1'b0;
        load_addr = 8'h00;
        load_data = 8'h00;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        test_reset();
        test_program();
        test_interrupt();
        summarize();
    end
endmodule : cpu_cycle_command_sequencer_test
